/* verilog/smmx_exit.sv */
// Management-exit control block with AXI4-Lite register access.
`timescale 1ns/1ps

module smmx_exit
    import smmx_pkg::*;
(
    // Clock, reset and enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // AXI4-Lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Core events, one-cycle pulses
    input  wire logic        smi_evt,
    input  wire logic        io_smi,
    input  wire logic        hv_call_evt,
    input  wire logic        leave_virt_evt,
    input  wire logic        resume_evt,
    input  wire logic        iret_evt,
    input  wire logic        entry_unblk_nmi,
    input  wire logic        entry_return_mgmt,
    // Core context levels
    input  wire logic        in_root,
    input  wire logic        in_nonroot,
    input  wire logic        trap_pending,
    input  wire logic        mode64,
    input  wire logic        seg_usable,
    input  wire logic        save_timer_ctl,
    input  wire logic        act_timer_ctl,
    input  wire logic        unrestricted_ctl,
    input  wire logic [31:0] primary_ctls,
    input  wire logic        pe_restored,
    input  wire logic        pg_restored,
    input  wire logic        pe_fixed_cap,
    input  wire logic        pg_fixed_cap,
    // I/O instruction snapshot, management base and preemption timer
    input  wire logic [1:0]  io_size,
    input  wire logic        io_in,
    input  wire logic        io_string,
    input  wire logic        io_rep,
    input  wire logic        io_imm,
    input  wire logic [15:0] io_port,
    input  wire logic [63:0] io_linaddr,
    input  wire logic [31:0] io_cnt,
    input  wire logic [31:0] io_src,
    input  wire logic [31:0] io_dst,
    input  wire logic [31:0] io_ip,
    input  wire logic [31:0] mgmt_base,
    input  wire logic [31:0] preempt_timer,
    // Results to the core
    output logic             in_mgmt_mode,
    output logic             dual_active,
    output logic             smi_blocked,
    output logic             nmi_blocked,
    output logic             leave_virt_fail,
    output logic             resume_vm_exit,
    output logic             resume_ud,
    output logic             pe_out,
    output logic             pg_out,
    output logic             tlb_inv,
    output logic [15:0]      tlb_inv_tag,
    output logic             exit_done
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    smmx_state_t st_q;
    logic [31:0] monctl_q, reason_q, qual_q, exec_q, cur_q, xfer_q, von_q;
    logic [31:0] mb_q, lin_q, cnt_q, src_q, dst_q, ip_q, tmr_q;
    logic        mode_q, dual_q, smib_q, nmib_q, fail_q, rvx_q, rud_q;
    logic        inv_q, done_q, pe_q, pg_q;
    logic        root_q, ioevt_q, hv_q;

    // ------------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------------
    wire monv      = monctl_q[MON_VALID_BIT];
    wire hv_take   = hv_call_evt & in_root & ~mode_q & monv;
    wire smi_take  = smi_evt & ~mode_q & ~smib_q;
    wire exit_go   = (st_q == SMMX_IDLE) & (smi_take | hv_take);
    wire lv_ok     = leave_virt_evt & ~mode_q & ~dual_q;
    wire prim31    = primary_ctls[PRIM_CTL_BIT];
    wire keep_crs  = in_nonroot & unrestricted_ctl & prim31;
    wire [15:0] basic_code = hv_q ? RSN_HVCALL :
                             (ioevt_q ? RSN_IO_SMI : RSN_OTH_SMI);

    // Qualification assembly; reserved bits stay zero.
    wire [31:0] qual_w = {io_port, 9'h000, io_imm, io_rep, io_string,
                          io_in, 1'b0, io_size};

    // ------------------------------------------------------------------
    // Exit sequencer
    // ------------------------------------------------------------------
    // Interrupt exits never touch save memory: the sequence only writes
    // control-structure fields, which is the whole transfer.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= SMMX_IDLE;
            mode_q <= 1'b0;
            dual_q <= 1'b0;
            smib_q <= 1'b0;
            nmib_q <= 1'b0;
            root_q <= 1'b0;
            ioevt_q <= 1'b0;
            hv_q <= 1'b0;
            reason_q <= ZERO32;
            qual_q <= ZERO32;
            exec_q <= ZERO32;
            cur_q <= ZERO32;
            mb_q <= ZERO32;
            lin_q <= ZERO32;
            cnt_q <= ZERO32;
            src_q <= ZERO32;
            dst_q <= ZERO32;
            ip_q <= ZERO32;
            tmr_q <= ZERO32;
            inv_q <= 1'b0;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            rvx_q <= 1'b0;
            rud_q <= 1'b0;
            pe_q <= 1'b0;
            pg_q <= 1'b0;
        end else if (clk_en) begin
            inv_q <= 1'b0;
            done_q <= 1'b0;
            fail_q <= leave_virt_evt & dual_q;
            rvx_q <= resume_evt & mode_q & dual_q & in_nonroot;
            rud_q <= resume_evt & mode_q & dual_q & in_root;
            if (resume_evt & ~dual_q) begin
                pe_q <= keep_crs ? pe_restored : pe_fixed_cap;
                pg_q <= keep_crs ? pg_restored : pg_fixed_cap;
            end
            if (lv_ok & smib_q & ~monctl_q[MON_NOUNBLK_BIT]) begin
                smib_q <= 1'b0;
            end
            if (iret_evt | entry_unblk_nmi) begin
                nmib_q <= 1'b0;
            end
            if (entry_return_mgmt & mode_q) begin
                smib_q <= 1'b0;
                mode_q <= 1'b0;
            end
            case (st_q)
                SMMX_IDLE: begin
                    if (exit_go) begin
                        root_q <= in_root;
                        hv_q <= hv_take;
                        ioevt_q <= ~hv_take & io_smi;
                        mode_q <= 1'b1;
                        smib_q <= 1'b1;
                        nmib_q <= 1'b1;
                        if (hv_take) begin
                            dual_q <= 1'b1;
                        end
                        st_q <= SMMX_PTR;
                    end
                end
                SMMX_PTR: begin
                    exec_q <= root_q ? von_q : cur_q;
                    st_q <= SMMX_LOAD;
                end
                SMMX_LOAD: begin
                    cur_q <= xfer_q;
                    st_q <= SMMX_REC;
                end
                SMMX_REC: begin
                    reason_q <= {2'b00, root_q,
                                 ~root_q & trap_pending,
                                 12'h000, basic_code};
                    mb_q <= mgmt_base;
                    if (save_timer_ctl) begin
                        tmr_q <= preempt_timer;
                    end
                    if (ioevt_q) begin
                        qual_q <= qual_w;
                        cnt_q <= io_cnt;
                        src_q <= io_src;
                        dst_q <= io_dst;
                        ip_q <= io_ip;
                        if (io_string & seg_usable) begin
                            lin_q <= mode64 ? io_linaddr[31:0]
                                            : io_linaddr[31:0];
                        end
                    end
                    inv_q <= 1'b1;
                    st_q <= SMMX_DONE;
                end
                SMMX_DONE: begin
                    done_q <= 1'b1;
                    st_q <= SMMX_IDLE;
                end
                default: begin
                    st_q <= SMMX_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    logic        aw_q, w_q, bv_q, rv_q;
    logic [7:0]  awa_q;
    logic [31:0] wd_q, rd_q;
    logic [3:0]  ws_q;
    logic [1:0]  br_q, rr_q;

    function automatic logic known(input logic [7:0] a);
        known = (a <= ADDR_TIMER) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    wire wr_go = aw_q & w_q & ~bv_q;
    wire rd_go = s_axi_arvalid & ~rv_q;

    assign s_axi_awready = ~aw_q & ~bv_q;
    assign s_axi_wready  = ~w_q & ~bv_q;
    assign s_axi_arready = ~rv_q;
    assign s_axi_bvalid  = bv_q;
    assign s_axi_bresp   = br_q;
    assign s_axi_rvalid  = rv_q;
    assign s_axi_rdata   = rd_q;
    assign s_axi_rresp   = rr_q;

    wire [31:0] status_w = {24'h00_0000, 1'b0, done_q, ~(st_q == SMMX_IDLE),
                            nmib_q, smib_q, dual_q, mode_q, 1'b0};

    logic [31:0] rmux;
    always_comb begin
        case (s_axi_araddr)
            ADDR_MONCTL:   rmux = monctl_q;
            ADDR_STATUS:   rmux = status_w;
            ADDR_REASON:   rmux = reason_q;
            ADDR_QUAL:     rmux = qual_q;
            ADDR_EXEC_LO:  rmux = exec_q;
            ADDR_CUR_LO:   rmux = cur_q;
            ADDR_XFER_LO:  rmux = xfer_q;
            ADDR_VON_LO:   rmux = von_q;
            ADDR_SAVED_MB: rmux = mb_q;
            ADDR_LINADDR:  rmux = lin_q;
            ADDR_IO_CNT:   rmux = cnt_q;
            ADDR_IO_SRC:   rmux = src_q;
            ADDR_IO_DST:   rmux = dst_q;
            ADDR_IO_IP:    rmux = ip_q;
            ADDR_TIMER:    rmux = tmr_q;
            default:       rmux = ZERO32;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bv_q <= 1'b0;
            rv_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= ZERO32;
            ws_q <= 4'h0;
            br_q <= RESP_OKAY;
            rr_q <= RESP_OKAY;
            rd_q <= ZERO32;
            monctl_q <= ZERO32;
            xfer_q <= ZERO32;
            von_q <= ZERO32;
        end else if (clk_en) begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_q <= 1'b1;
                awa_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_q <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bv_q <= 1'b1;
                br_q <= known(awa_q) ? RESP_OKAY : RESP_SLVERR;
                case (awa_q)
                    ADDR_MONCTL:  monctl_q <= merge(monctl_q, wd_q, ws_q);
                    ADDR_XFER_LO: xfer_q <= merge(xfer_q, wd_q, ws_q);
                    ADDR_VON_LO:  von_q <= merge(von_q, wd_q, ws_q);
                    default:      ;
                endcase
            end else if (bv_q & s_axi_bready) begin
                bv_q <= 1'b0;
            end
            if (rd_go) begin
                rv_q <= 1'b1;
                rd_q <= rmux;
                rr_q <= known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (rv_q & s_axi_rready) begin
                rv_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign in_mgmt_mode    = mode_q;
    assign dual_active     = dual_q;
    assign smi_blocked     = smib_q;
    assign nmi_blocked     = nmib_q;
    assign leave_virt_fail = fail_q;
    assign resume_vm_exit  = rvx_q;
    assign resume_ud       = rud_q;
    assign pe_out          = pe_q;
    assign pg_out          = pg_q;
    assign tlb_inv         = inv_q;
    assign tlb_inv_tag     = TAG_ZERO;
    assign exit_done       = done_q;

endmodule

/* verilog/smmx_pkg.sv */
// Package of constants and types for the management-exit control block.
package smmx_pkg;

    // ------------------------------------------------------------------
    // Register map (AXI4-Lite byte offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_MONCTL    = 8'h04;
    localparam logic [7:0] ADDR_STATUS    = 8'h08;
    localparam logic [7:0] ADDR_REASON    = 8'h0C;
    localparam logic [7:0] ADDR_QUAL      = 8'h10;
    localparam logic [7:0] ADDR_EXEC_LO   = 8'h14;
    localparam logic [7:0] ADDR_CUR_LO    = 8'h18;
    localparam logic [7:0] ADDR_XFER_LO   = 8'h1C;
    localparam logic [7:0] ADDR_VON_LO    = 8'h20;
    localparam logic [7:0] ADDR_SAVED_MB  = 8'h24;
    localparam logic [7:0] ADDR_LINADDR   = 8'h28;
    localparam logic [7:0] ADDR_IO_CNT    = 8'h2C;
    localparam logic [7:0] ADDR_IO_SRC    = 8'h30;
    localparam logic [7:0] ADDR_IO_DST    = 8'h34;
    localparam logic [7:0] ADDR_IO_IP     = 8'h38;
    localparam logic [7:0] ADDR_TIMER     = 8'h3C;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int MON_VALID_BIT    = 0;
    localparam int MON_NOUNBLK_BIT  = 2;
    localparam int RSN_ROOT_BIT     = 29;
    localparam int RSN_TRAP_BIT     = 28;
    localparam int QUAL_DIR_BIT     = 3;
    localparam int QUAL_STR_BIT     = 4;
    localparam int QUAL_REP_BIT     = 5;
    localparam int QUAL_IMM_BIT     = 6;
    localparam int QUAL_PORT_LSB    = 16;
    localparam int PRIM_CTL_BIT     = 31;

    // Basic exit reasons; codes are local choices.
    localparam logic [15:0] RSN_IO_SMI   = 16'h0005;
    localparam logic [15:0] RSN_OTH_SMI  = 16'h0006;
    localparam logic [15:0] RSN_HVCALL   = 16'h0012;

    localparam logic [15:0] TAG_ZERO     = 16'h0000;
    localparam logic [31:0] ZERO32       = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;

    // Exit sequencer states.
    typedef enum logic [2:0] {
        SMMX_IDLE  = 3'b000,
        SMMX_PTR   = 3'b001,
        SMMX_LOAD  = 3'b010,
        SMMX_REC   = 3'b011,
        SMMX_DONE  = 3'b100
    } smmx_state_t;

endpackage

/* verif/smmx_exit_asserts.sv */
// Concurrent checks on the ports of the management-exit control block.
`timescale 1ns/1ps
module smmx_exit_asserts
    import smmx_pkg::*;
(
    // Clock, reset and enable
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        clk_en,
    // Core events and context
    input wire logic        smi_evt,
    input wire logic        leave_virt_evt,
    input wire logic        resume_evt,
    input wire logic        in_root,
    input wire logic        in_nonroot,
    input wire logic        unrestricted_ctl,
    input wire logic [31:0] primary_ctls,
    input wire logic        pe_restored,
    input wire logic        pg_restored,
    // Results
    input wire logic        in_mgmt_mode,
    input wire logic        dual_active,
    input wire logic        smi_blocked,
    input wire logic        nmi_blocked,
    input wire logic        leave_virt_fail,
    input wire logic        resume_vm_exit,
    input wire logic        resume_ud,
    input wire logic        pe_out,
    input wire logic        pg_out,
    input wire logic        tlb_inv,
    input wire logic [15:0] tlb_inv_tag,
    input wire logic        exit_done
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ------------------------------
    // Properties
    // ------------------------------
    a_smi_enters_mode: assert property (
        smi_evt && clk_en && !in_mgmt_mode && !smi_blocked
        |=> in_mgmt_mode && smi_blocked && nmi_blocked)
        else $error("interrupt did not enter management mode");
    a_done_delay: assert property (
        $rose(in_mgmt_mode) |-> ##4 exit_done)
        else $error("exit done not four cycles after entry");
    a_done_not_early: assert property (
        $rose(in_mgmt_mode) |-> !exit_done [*4])
        else $error("exit done too early");
    a_inv_window: assert property (
        $rose(in_mgmt_mode)
        |-> ##[3:4] (tlb_inv && tlb_inv_tag == TAG_ZERO))
        else $error("translation invalidate missing or wrong tag");
    a_leave_result: assert property (
        leave_virt_evt && clk_en
        |=> leave_virt_fail == $past(dual_active))
        else $error("leave result does not follow dual state");
    a_fail_cause: assert property (
        leave_virt_fail |-> $past(leave_virt_evt))
        else $error("leave failure without leave event");
    a_resume_root: assert property (
        resume_evt && clk_en && in_mgmt_mode && dual_active && in_root
        |=> resume_ud && !resume_vm_exit)
        else $error("resume in root did not fault");
    a_resume_guest: assert property (
        resume_evt && clk_en && in_mgmt_mode && dual_active
        && in_nonroot && !in_root
        |=> resume_vm_exit && !resume_ud)
        else $error("resume in guest did not exit");
    a_resume_keeps: assert property (
        resume_evt && clk_en && in_mgmt_mode && !dual_active
        && in_nonroot && unrestricted_ctl && primary_ctls[PRIM_CTL_BIT]
        |=> pe_out == $past(pe_restored) && pg_out == $past(pg_restored))
        else $error("resume lost restored enable bits");
    a_dual_on_exit: assert property (
        $rose(dual_active) |-> $rose(in_mgmt_mode))
        else $error("dual scheme activated without an exit");

    // ------------------------------
    // Covers
    // ------------------------------
    c_exit: cover property ($rose(in_mgmt_mode));
    c_fail: cover property (leave_virt_fail);
    c_ud: cover property (resume_ud);
    c_vmexit: cover property (resume_vm_exit);
endmodule

bind smmx_exit smmx_exit_asserts u_chk (.*);

/* verif/smmx_exit_tb.sv */
// Self-checking testbench for the management-exit control block.
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    mismatches++; $display("Error %s expected %h seen %h", n, e, g); \
    end end
module smmx_exit_tb
    import smmx_pkg::*;
;
    typedef struct packed {
        logic io, root, trap;
        logic [1:0] sz;
        logic dir, str, rep, imm;
        logic [15:0] port;
        logic [31:0] base, rsn, qual, exec;
    } smmx_row_t;
    localparam logic [31:0] XFER_PTR = 32'h0003_A000;
    localparam logic [31:0] VON_PTR  = 32'h0007_C000;
    localparam logic [5:0]  E_SMI = 6'h20, E_HV = 6'h10, E_LV = 6'h08;
    localparam logic [5:0]  E_RS = 6'h04, E_IRET = 6'h02, E_RET = 6'h01;
    logic        aclk, aresetn, clk_en;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, io_size, rs;
    logic        smi_evt, hv_call_evt, leave_virt_evt, resume_evt;
    logic        iret_evt, entry_return_mgmt, io_smi, entry_unblk_nmi;
    logic        in_root, in_nonroot, trap_pending, mode64, seg_usable;
    logic        save_timer_ctl, act_timer_ctl, unrestricted_ctl;
    logic        pe_restored, pg_restored, pe_fixed_cap, pg_fixed_cap;
    logic        io_in, io_string, io_rep, io_imm;
    logic [15:0] io_port, tlb_inv_tag;
    logic [63:0] io_linaddr;
    logic [31:0] primary_ctls, mgmt_base, preempt_timer, d;
    logic [31:0] io_cnt, io_src, io_dst, io_ip;
    logic        in_mgmt_mode, dual_active, smi_blocked, nmi_blocked;
    logic        leave_virt_fail, resume_vm_exit, resume_ud;
    logic        pe_out, pg_out, tlb_inv, exit_done;
    logic [5:0]  ev;
    int          mismatches, tests_run;
    smmx_row_t   rows [4];
    smmx_row_t   r;

    assign {smi_evt, hv_call_evt, leave_virt_evt, resume_evt, iret_evt,
            entry_return_mgmt} = ev;
    smmx_exit DUT (.*);
    always #10 aclk = ~aclk;

    // ------------------------------
    // Bus and event tasks
    // ------------------------------
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!((!s_axi_awvalid || s_axi_awready)
                   && (!s_axi_wvalid || s_axi_wready)) && n < 50);
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        `CHK("write_wait", 1'b1, n < 50)
    endtask

    task automatic axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_arready !== 1'b1 && n < 50);
        s_axi_arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        d  = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        `CHK("read_wait", 1'b1, n < 50)
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input string n);
        axi_rd(a);
        `CHK(n, e, d)
    endtask

    // Events are one-cycle pulses, so the mask drops after one edge.
    task automatic pulse(input logic [5:0] m);
        @(posedge aclk);
        ev <= m;
        @(posedge aclk);
        ev <= 6'h00;
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (exit_done !== 1'b1 && n < 20);
        `CHK("exit_done", 1'b1, exit_done)
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge aclk);
        mismatches++;
        $display("Error watchdog expected finish seen hang");
        end_sim();
    end

    // ------------------------------
    // Tests
    // ------------------------------
    initial begin
        {aclk, aresetn, ev, mismatches, tests_run} = '0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid,
         s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready,
         io_smi, entry_unblk_nmi, in_root, in_nonroot, trap_pending,
         mode64, save_timer_ctl, act_timer_ctl, unrestricted_ctl,
         primary_ctls, pe_restored, pg_restored, pe_fixed_cap,
         pg_fixed_cap, io_size, io_in, io_string, io_rep, io_imm,
         io_port, mgmt_base, io_cnt, io_src, io_dst, io_ip,
         io_linaddr, preempt_timer} = '0;
        {clk_en, seg_usable, s_axi_wstrb} = 6'h3F;
        rows[0] = '{1'b1, 1'b0, 1'b1, 2'd3, 1'b1, 1'b1, 1'b1, 1'b0,
                    16'h5A3C, 32'h000A_0000, {4'h1, 12'h000, RSN_IO_SMI},
                    32'h5A3C_003B, ZERO32};
        rows[1] = '{1'b0, 1'b1, 1'b1, 2'd0, 1'b0, 1'b0, 1'b0, 1'b0,
                    16'h0000, 32'h000B_8000, {4'h2, 12'h000, RSN_OTH_SMI},
                    ZERO32, VON_PTR};
        rows[2] = '{1'b1, 1'b1, 1'b0, 2'd0, 1'b0, 1'b0, 1'b0, 1'b1,
                    16'h0080, 32'h000C_0000, {4'h2, 12'h000, RSN_IO_SMI},
                    32'h0080_0040, VON_PTR};
        rows[3] = '{1'b0, 1'b0, 1'b0, 2'd0, 1'b0, 1'b0, 1'b0, 1'b0,
                    16'h0000, 32'h000D_0000, {4'h0, 12'h000, RSN_OTH_SMI},
                    ZERO32, XFER_PTR};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_wr(ADDR_XFER_LO, XFER_PTR);
        axi_wr(ADDR_VON_LO, VON_PTR);
        foreach (rows[i]) begin
            r = rows[i];
            @(posedge aclk);
            // Row fields above the three result words line up with these.
            {io_smi, in_root, trap_pending, io_size, io_in, io_string, io_rep,
             io_imm, io_port, mgmt_base} <= r[152:96];
            in_nonroot <= !r.root;
            {save_timer_ctl, act_timer_ctl} <= {2{i == 3}};
            {io_cnt, io_src, io_dst, io_ip, preempt_timer} <=
                {r.base + 1, r.base + 2, r.base + 3, r.base + 4, r.base + 5};
            io_linaddr <= {2{r.base + 32'd6}};
            pulse(E_SMI);
            wait_done();
            `CHK("blocks", 3'b111, {in_mgmt_mode, smi_blocked, nmi_blocked})
            rd_chk(ADDR_REASON, r.rsn, "reason");
            rd_chk(ADDR_EXEC_LO, r.exec, "exec");
            rd_chk(ADDR_CUR_LO, XFER_PTR, "current");
            rd_chk(ADDR_SAVED_MB, r.base, "base");
            if (r.io) begin
                rd_chk(ADDR_QUAL, r.qual, "qual");
                rd_chk(ADDR_IO_IP, r.base + 32'd4, "io_ip");
                rd_chk(ADDR_IO_DST, r.base + 32'd3, "io_dst");
            end
            if (i == 0) rd_chk(ADDR_LINADDR, r.base + 32'd6, "lin");
            if (i == 3) rd_chk(ADDR_TIMER, r.base + 32'd5, "timer");
            pulse(E_RET);
            @(posedge aclk);
            `CHK("unblock", 2'b00, {in_mgmt_mode, smi_blocked})
            $display("Row %0d done", i);
        end
        // Default treatment: resume keeps restored enables; IRET unblocks.
        unrestricted_ctl <= 1'b1;
        primary_ctls <= 32'h8000_0000;
        {pe_restored, pg_restored, pe_fixed_cap, pg_fixed_cap} <= 4'b1001;
        pulse(E_SMI);
        wait_done();
        pulse(E_RS);
        @(posedge aclk);
        `CHK("pe_pg", 2'b10, {pe_out, pg_out})
        pulse(E_IRET);
        @(posedge aclk);
        `CHK("nmi", 1'b0, nmi_blocked)
        pulse(E_RET);
        $display("Resume under default treatment done");
        // Hypervisor call is ignored until the valid bit is set.
        {in_root, in_nonroot} <= 2'b10;
        pulse(E_HV);
        repeat (3) @(posedge aclk);
        `CHK("hv_ignored", 1'b0, in_mgmt_mode)
        clk_en <= 1'b0;
        pulse(E_SMI);
        @(posedge aclk);
        `CHK("frozen", 1'b0, in_mgmt_mode)
        clk_en <= 1'b1;
        axi_wr(ADDR_MONCTL, 32'h0000_0005);
        rd_chk(ADDR_MONCTL, 32'h0000_0005, "monctl");
        pulse(E_HV);
        wait_done();
        `CHK("dual", 1'b1, dual_active)
        rd_chk(ADDR_REASON, {4'h2, 12'h000, RSN_HVCALL}, "hv_rsn");
        rd_chk(ADDR_EXEC_LO, VON_PTR, "hv_exec");
        pulse(E_RS);
        @(posedge aclk);
        `CHK("resume_root", 2'b01, {resume_vm_exit, resume_ud})
        {in_root, in_nonroot} <= 2'b01;
        pulse(E_RS);
        @(posedge aclk);
        `CHK("resume_guest", 2'b10, {resume_vm_exit, resume_ud})
        pulse(E_LV);
        @(posedge aclk);
        `CHK("leave_fail", 1'b1, leave_virt_fail)
        $display("Dual scheme tests done");
        rd_chk(8'h40, ZERO32, "unmapped");
        `CHK("unmapped_resp", RESP_SLVERR, rs)
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        `CHK("reset", 4'h0, {in_mgmt_mode, dual_active, smi_blocked,
                             nmi_blocked})
        aresetn <= 1'b1;
        $display("Bus and reset tests done");
        end_sim();
    end
endmodule
